// ---- fps_defines.svh ----
/*
 * constants of the flash program/erase sequencer: register offsets, key
 * values, result codes, array geometry and operation times.
 * assumes a 20 MHz mclk and byte addresses on a 32-bit APB.
 */
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// register byte offsets
`define FPS_OFF_KEY 8'h00
`define FPS_OFF_PSEL 8'h04
`define FPS_OFF_ESEL 8'h08
`define FPS_OFF_DLTGT 8'h0C
`define FPS_OFF_CODE 8'h10
`define FPS_OFF_DLRES 8'h14
`define FPS_OFF_ARRSEL 8'h18
`define FPS_OFF_ARG0 8'h1C
`define FPS_OFF_ARG1 8'h20
`define FPS_OFF_CALL 8'h24
`define FPS_OFF_RESULT 8'h28
`define FPS_OFF_STATUS 8'h2C

// key and array select values
`define FPS_KEY_DL 8'hA5
`define FPS_KEY_PE 8'h5A
`define FPS_ARR_BOOT 8'hAA
`define FPS_ARR_USER 8'h00

// routine entry offsets from the download base
`define FPS_ENTRY_OFS 16'h0010
`define FPS_INIT_OFS 16'h0020

// call codes
`define FPS_CALL_INIT 2'h1
`define FPS_CALL_PROG 2'h2
`define FPS_CALL_ERASE 2'h3

// download result bits
`define FPS_DL_OK 8'h00
`define FPS_DL_SS 8'h04
`define FPS_DL_FK 8'h02

// call result codes
`define FPS_RES_OK 8'h00
`define FPS_RES_KEY 8'h02
`define FPS_RES_ADDR 8'h04
`define FPS_RES_SRC 8'h08
`define FPS_RES_WRERR 8'h10
`define FPS_RES_FREQ 8'h20
`define FPS_RES_NODL 8'h40
`define FPS_RES_MAT 8'h80
`define FPS_RES_BUSY 8'hFF

// operating frequency range, MHz times 100
`define FPS_FREQ_MIN 32'h0000_07D0
`define FPS_FREQ_MAX 32'h0000_09C4

// user array geometry: 32 units of 128 bytes, 8 blocks of 4 units
`define FPS_NUM_UNITS 32
`define FPS_NUM_BLOCKS 8
`define FPS_ARRAY_TOP 32'h0000_1000
`define FPS_UNIT_MASK 32'h0000_007F

// operation times in microseconds and their cycle counts
`define FPS_CLK_MHZ 20
`define FPS_CHECK_US 50
`define FPS_DL_US 5
`define FPS_PROG_US 10
`define FPS_ERASE_US 100
`define FPS_SWITCH_US 1
// edges before the synchronised mode pin is valid after reset
`define FPS_SYNC_CYC 12'h003
`define FPS_CYC(us) 12'((us) * `FPS_CLK_MHZ)

`endif

// ---- fps_pkg.sv ----
/*
 * types of the flash program/erase sequencer.
 * assumes fps_defines.svh for all numeric constants.
 */
package fps_pkg;
    // sequencer phase
    typedef enum logic [2:0] {
        PH_CHECK,
        PH_IDLE,
        PH_DOWNLOAD,
        PH_SWITCH,
        PH_OPER
    } fps_phase_t;
endpackage : fps_pkg

// ---- fps_sync.sv ----
/*
 * two flip-flop synchroniser for asynchronous level inputs.
 * assumes inputs are slow levels such as mode pins.
 */
`timescale 1ns/1ps
module fps_sync #(
    parameter int WIDTH = 2
) (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [WIDTH-1:0] asyncIn, // raw levels
    output logic [WIDTH-1:0] syncOut // synchronised levels
);
    // one pair of stages per bit
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic stage1Reg;
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                stage1Reg <= 1'b0;
                syncOut[i] <= 1'b0;
            end else begin
                stage1Reg <= asyncIn[i];
                syncOut[i] <= stage1Reg;
            end
        end
    end
endmodule : fps_sync

// ---- fps_top.sv ----
/*
 * flash program/erase sequencer: key and select registers, routine
 * download, init/program/erase calls, user/boot array switching and
 * the reset check of user boot mode, all reached over APB.
 * assumes a 20 MHz mclk, a synchronous reset and an APB master that
 * holds each request until pready.
 */
// The register offsets and register access over APB are this design's own decisions.
// Functional notes
// R1 - program routine entry sits at download base plus 16 bytes
// R2 - calls change no argument register, only the low return byte
// R3 - call outcome is delivered in the low return byte register
// R4 - caller reserves up to 128 bytes of RAM stack first
// R5 - caller programs long data in 128-byte steps, advancing pointers
// R6 - reprogramming a programmed unit returns an error; caller must avoid it
// R7 - reset after program or erase is held low at least 100 us
// R8 - each erase call erases exactly one block
// R9 - caller sets the erase routine select bit to pick erase
// R10 - several routines selected: no download, selection error reported
// R11 - invalid block number: nothing erased, error returned
// R12 - erase routine entry sits at download base plus 16 bytes
// R13 - erasing an already erased block succeeds
// R14 - caller initialises each downloaded area at its base plus 32
// R15 - user boot mode may only program or erase the user array
// R16 - user boot reset runs a check with all interrupts held
// R17 - after the check the array select register reads AA
// R18 - no array access or interrupt during an array switch
// R19 - boot array visible in user boot mode except when swapped
// R20 - caller sets download request from RAM, not from the erased array
// R21 - caller clears the key and protects after finishing
// R22 - download request only accepted while key holds A5
// R23 - caller loads key 5A before program or erase calls
// R24 - download result 00 is success, else error bits
// R25 - caller aligns program destination to 128 bytes
// R26 - array fetches blocked while program or erase runs
`timescale 1ns/1ps
`include "fps_defines.svh"
module fps_top (
    input wire logic mclk, // system clock, 20 MHz
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [7:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic userBootPin, // mode pin, user boot mode
    input wire logic ramExec, // cpu is fetching from on-chip ram
    output logic irqHold, // interrupts and nmi held off
    output logic arrayBlock, // array fetches and reads refused
    output logic bootArrayVisible, // boot array mapped in flash space
    output logic [15:0] entryAddr, // program or erase entry address
    output logic [15:0] initEntryAddr, // initialisation entry address
    output fps_pkg::fps_phase_t phase // sequencer phase
);
    import fps_pkg::*;

    logic [0:0] pinSync;
    logic userBoot;
    logic [7:0] keyReg;
    logic progSelReg;
    logic eraseSelReg;
    logic [15:0] dlTargetReg;
    logic [7:0] dlResultReg;
    logic [7:0] arraySelReg;
    logic [7:0] arraySelNext;
    logic [31:0] arg0Reg;
    logic [31:0] arg1Reg;
    logic [7:0] resultReg;
    logic progLoadedReg;
    logic eraseLoadedReg;
    logic [1:0] opReg;
    logic [11:0] cntReg;
    logic [`FPS_NUM_UNITS-1:0] programmedReg;
    logic wrEn;
    logic [7:0] callErr;
    logic [4:0] unitIdx;
    logic [2:0] blockIdx;
    logic opDone;
    logic pready_next;

    // mode pin into the clock domain
    fps_sync #(.WIDTH(1)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .asyncIn(userBootPin),
        .syncOut(pinSync)
    );
    assign userBoot = pinSync[0];

    // address compare, used by every register write
    function automatic logic isReg(input logic [7:0] a, input logic [7:0] off);
        isReg = (a == off);
    endfunction : isReg

    // known word addresses
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a[1:0] == 2'b00) && (a <= `FPS_OFF_STATUS);
    endfunction : isMapped

    // apb: one wait state, write lands on the ready edge
    assign pready_next = psel & penable & ~pready;
    assign wrEn = psel & penable & pwrite & pready;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= pready_next;
            pslverr <= pready_next & ~isMapped(paddr);
        end
    end

    // read data captured with ready
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (pready_next & ~pwrite) begin
            case (paddr)
                `FPS_OFF_KEY: prdata <= {24'h00_0000, keyReg};
                `FPS_OFF_PSEL: prdata <= {31'h0000_0000, progSelReg};
                `FPS_OFF_ESEL: prdata <= {31'h0000_0000, eraseSelReg};
                `FPS_OFF_DLTGT: prdata <= {16'h0000, dlTargetReg};
                `FPS_OFF_CODE: prdata <= {31'h0000_0000, phase == PH_DOWNLOAD};
                `FPS_OFF_DLRES: prdata <= {24'h00_0000, dlResultReg};
                `FPS_OFF_ARRSEL: prdata <= {24'h00_0000, arraySelReg};
                `FPS_OFF_ARG0: prdata <= arg0Reg;
                `FPS_OFF_ARG1: prdata <= arg1Reg;
                `FPS_OFF_CALL: prdata <= {30'h0000_0000, opReg};
                `FPS_OFF_RESULT: prdata <= {24'h00_0000, resultReg};
                `FPS_OFF_STATUS: prdata <= {27'h000_0000, userBoot,
                    arraySelReg == `FPS_ARR_BOOT, phase == PH_SWITCH,
                    phase == PH_CHECK, phase != PH_IDLE};
                default: prdata <= 32'h0000_0000;
            endcase
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // key, selects, target and argument registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            keyReg <= 8'h00;
            progSelReg <= 1'b0;
            eraseSelReg <= 1'b0;
            dlTargetReg <= 16'h0000;
            arg0Reg <= 32'h0000_0000;
            arg1Reg <= 32'h0000_0000;
        end else if (wrEn) begin
            if (isReg(paddr, `FPS_OFF_KEY)) begin
                keyReg <= pwdata[7:0];
            end
            if (isReg(paddr, `FPS_OFF_PSEL)) begin
                progSelReg <= pwdata[0];
            end
            // R9 erase routine select
            if (isReg(paddr, `FPS_OFF_ESEL)) begin
                eraseSelReg <= pwdata[0];
            end
            if (isReg(paddr, `FPS_OFF_DLTGT) && phase == PH_IDLE) begin
                dlTargetReg <= pwdata[15:0];
            end
            if (isReg(paddr, `FPS_OFF_ARG0)) begin
                arg0Reg <= pwdata;
            end
            if (isReg(paddr, `FPS_OFF_ARG1)) begin
                arg1Reg <= pwdata;
            end
        end
    end

    // R1 R12 entry points from download base
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            entryAddr <= `FPS_ENTRY_OFS;
            initEntryAddr <= `FPS_INIT_OFS;
        end else begin
            entryAddr <= dlTargetReg + `FPS_ENTRY_OFS;
            initEntryAddr <= dlTargetReg + `FPS_INIT_OFS;
        end
    end

    // unit and block decoded from the call arguments
    assign unitIdx = arg1Reg[11:7];
    assign blockIdx = arg0Reg[2:0];

    // call checks before any flash activity
    always_comb begin
        callErr = `FPS_RES_OK;
        case (pwdata[1:0])
            `FPS_CALL_INIT: begin
                if (!progLoadedReg && !eraseLoadedReg) begin
                    callErr = `FPS_RES_NODL;
                end else if (arg0Reg < `FPS_FREQ_MIN || arg0Reg > `FPS_FREQ_MAX) begin
                    callErr = `FPS_RES_FREQ;
                end
            end
            `FPS_CALL_PROG: begin
                if (!progLoadedReg) begin
                    callErr = `FPS_RES_NODL;
                end else if (keyReg != `FPS_KEY_PE) begin
                    callErr = `FPS_RES_KEY;
                // R15 boot array locked here
                end else if (arraySelReg == `FPS_ARR_BOOT) begin
                    callErr = `FPS_RES_MAT;
                end else if (arg1Reg >= `FPS_ARRAY_TOP || (arg1Reg & `FPS_UNIT_MASK) != 32'h0000_0000) begin
                    callErr = `FPS_RES_ADDR;
                end else if (arg0Reg < `FPS_ARRAY_TOP) begin
                    callErr = `FPS_RES_SRC;
                // R6 programmed unit refused
                end else if (programmedReg[unitIdx]) begin
                    callErr = `FPS_RES_WRERR;
                end
            end
            `FPS_CALL_ERASE: begin
                if (!eraseLoadedReg) begin
                    callErr = `FPS_RES_NODL;
                end else if (keyReg != `FPS_KEY_PE) begin
                    callErr = `FPS_RES_KEY;
                end else if (arraySelReg == `FPS_ARR_BOOT) begin
                    callErr = `FPS_RES_MAT;
                // R11 invalid block refused
                end else if (arg0Reg >= `FPS_NUM_BLOCKS) begin
                    callErr = `FPS_RES_ADDR;
                end
            end
            default: callErr = `FPS_RES_NODL;
        endcase
    end

    assign opDone = (cntReg == 12'h000);

    // sequencer phase and timer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase <= PH_CHECK;
            cntReg <= `FPS_CYC(`FPS_CHECK_US);
            opReg <= 2'h0;
        end else begin
            case (phase)
                // R16 reset check holds interrupts
                PH_CHECK: begin
                    cntReg <= cntReg - 12'h001;
                    // the synchroniser reads low for its first edges, so wait before trusting it
                    if (opDone || (!userBoot && cntReg <= `FPS_CYC(`FPS_CHECK_US) - `FPS_SYNC_CYC)) begin
                        phase <= PH_IDLE;
                    end
                end
                PH_IDLE: begin
                    // R22 download needs key A5
                    if (wrEn && isReg(paddr, `FPS_OFF_CODE) && pwdata[0]
                        && keyReg == `FPS_KEY_DL && ramExec) begin
                        phase <= PH_DOWNLOAD;
                        cntReg <= `FPS_CYC(`FPS_DL_US);
                    end else if (wrEn && isReg(paddr, `FPS_OFF_ARRSEL) && userBoot) begin
                        phase <= PH_SWITCH;
                        cntReg <= `FPS_CYC(`FPS_SWITCH_US);
                    end else if (wrEn && isReg(paddr, `FPS_OFF_CALL) && callErr == `FPS_RES_OK) begin
                        phase <= PH_OPER;
                        opReg <= pwdata[1:0];
                        cntReg <= (pwdata[1:0] == `FPS_CALL_ERASE) ? `FPS_CYC(`FPS_ERASE_US) :
                            `FPS_CYC(`FPS_PROG_US);
                    end
                end
                PH_DOWNLOAD, PH_SWITCH, PH_OPER: begin
                    cntReg <= cntReg - 12'h001;
                    if (opDone) begin
                        phase <= PH_IDLE;
                    end
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end

    // download outcome and loaded routine
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dlResultReg <= `FPS_DL_OK;
            progLoadedReg <= 1'b0;
            eraseLoadedReg <= 1'b0;
        end else if (phase == PH_DOWNLOAD && opDone) begin
            // R10 single routine only
            if (progSelReg == eraseSelReg) begin
                dlResultReg <= `FPS_DL_SS;
            // R24 zero means success
            end else begin
                dlResultReg <= `FPS_DL_OK;
                progLoadedReg <= progLoadedReg | progSelReg;
                eraseLoadedReg <= eraseLoadedReg | eraseSelReg;
            end
        end
    end

    // R2 R3 only the return byte changes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            resultReg <= `FPS_RES_OK;
        end else if (phase == PH_IDLE && wrEn && isReg(paddr, `FPS_OFF_CALL)) begin
            resultReg <= (callErr == `FPS_RES_OK) ? `FPS_RES_BUSY : callErr;
        end else if (phase == PH_OPER && opDone) begin
            resultReg <= `FPS_RES_OK;
        end
    end

    // array select value taken by a switch
    always_comb begin
        arraySelNext = (pwdata[7:0] == `FPS_ARR_BOOT) ? `FPS_ARR_BOOT : `FPS_ARR_USER;
    end

    // R17 R19 boot array after user boot check
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            arraySelReg <= `FPS_ARR_USER;
        end else if (phase == PH_CHECK) begin
            arraySelReg <= userBoot ? `FPS_ARR_BOOT : `FPS_ARR_USER;
        end else if (phase == PH_IDLE && wrEn && isReg(paddr, `FPS_OFF_ARRSEL) && userBoot) begin
            arraySelReg <= arraySelNext;
        end
    end

    // per-unit programmed state
    for (genvar u = 0; u < `FPS_NUM_UNITS; u++) begin : g_unit
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                programmedReg[u] <= 1'b0;
            end else if (phase == PH_OPER && opDone) begin
                if (opReg == `FPS_CALL_PROG && unitIdx == 5'(u)) begin
                    programmedReg[u] <= 1'b1;
                // R8 R13 one block, erased or not
                end else if (opReg == `FPS_CALL_ERASE && blockIdx == 3'(u / 4)) begin
                    programmedReg[u] <= 1'b0;
                end
            end
        end
    end

    // R18 R26 array and interrupt guards
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irqHold <= 1'b1;
            arrayBlock <= 1'b1;
            bootArrayVisible <= 1'b0;
        end else begin
            irqHold <= (phase == PH_CHECK) || (phase == PH_DOWNLOAD) || (phase == PH_SWITCH);
            arrayBlock <= (phase == PH_OPER) || (phase == PH_SWITCH) || (phase == PH_CHECK);
            bootArrayVisible <= (arraySelReg == `FPS_ARR_BOOT);
        end
    end
endmodule : fps_top

// ---- fps_top_props.sv ----
/*
 * checker of the flash program/erase sequencer ports.
 * assumes binding to fps_top, mclk rising edge, sys_rst synchronous high.
 */
`timescale 1ns/1ps
module fps_top_props (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic userBootPin, // mode pin
    input wire logic irqHold, // interrupts held
    input wire logic arrayBlock, // array access refused
    input wire logic bootArrayVisible, // boot array mapped
    input wire logic [15:0] entryAddr, // routine entry
    input wire logic [15:0] initEntryAddr, // init entry
    input wire fps_pkg::fps_phase_t phase // sequencer phase
);
    import fps_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // apb answer timing, entry spacing and phase guards
    chk_one_wait: assert property (psel && !penable |-> ##2 (pready && psel && penable))
        else $error("apb answer not after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("slave error without ready or with data");
    chk_entry_pair: assert property (initEntryAddr == entryAddr + 16'h0010)
        else $error("init entry not 16 bytes above entry");
    chk_check_hold: assert property (phase == PH_CHECK |-> irqHold && arrayBlock)
        else $error("interrupts or array open during check");
    chk_oper_block: assert property (phase == PH_OPER |=> arrayBlock)
        else $error("array open during operation");
    chk_switch_hold: assert property (phase == PH_SWITCH |=> irqHold && arrayBlock)
        else $error("interrupts or array open during switch");
    chk_boot_shown: assert property ($past(phase) == PH_CHECK && phase == PH_IDLE && userBootPin
        |-> ##[0:1] bootArrayVisible)
        else $error("boot array not selected after check");
    chk_oper_len: assert property ($rose(phase == PH_OPER) |-> (phase == PH_OPER) [*8])
        else $error("operation ended too soon");

    cover_oper: cover property (phase == PH_OPER);
    cover_switch: cover property (phase == PH_SWITCH);
    cover_slverr: cover property (pslverr);
endmodule : fps_top_props

bind fps_top fps_top_props u_props (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .userBootPin(userBootPin), .irqHold(irqHold),
    .arrayBlock(arrayBlock), .bootArrayVisible(bootArrayVisible), .entryAddr(entryAddr),
    .initEntryAddr(initEntryAddr), .phase(phase));

// ---- fps_host_model.sv ----
/*
 * host cpu model: issues apb transfers for the user procedure.
 * assumes a slave that raises pready once per access.
 */
`timescale 1ns/1ps
module fps_host_model (
    input wire logic mclk, // system clock
    input wire logic pready, // slave ready
    input wire logic [31:0] prdata, // read data
    output logic [7:0] paddr, // byte address
    output logic psel, // select
    output logic penable, // access phase
    output logic pwrite, // direction
    output logic [31:0] pwdata // write data
);
    // bus idle at start
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
    end

    // one transfer, request held until pready is sampled high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data shows no stale value
    endtask : xfer
endmodule : fps_host_model

// ---- fps_top_tb.sv ----
/*
 * self-checking bench of the flash program/erase sequencer.
 * assumes fps_defines.svh, fps_pkg and the host model; reads checked via queue.
 */
`timescale 1ns/1ps
`include "fps_defines.svh"
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin failCount++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, a, e); end end
module fps_top_tb;
    import fps_pkg::*;
    logic mclk = 1'b0;
    logic sysRst, userBootPin, ramExec, psel, penable, pwrite, pready, pslverr;
    logic irqHold, arrayBlock, bootArrayVisible;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] entryAddr, initEntryAddr;
    fps_phase_t phase;
    logic [32:0] expQ[$];
    logic [32:0] expV;
    int failCount = 0;
    int totalChecks = 0;

    always #25 mclk = ~mclk;

    fps_top uut (.mclk(mclk), .sys_rst(sysRst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .userBootPin(userBootPin), .ramExec(ramExec), .irqHold(irqHold), .arrayBlock(arrayBlock),
        .bootArrayVisible(bootArrayVisible), .entryAddr(entryAddr), .initEntryAddr(initEntryAddr),
        .phase(phase));
    fps_host_model host (.mclk(mclk), .pready(pready), .prdata(prdata), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

    // read results against the oldest note
    always @(negedge mclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            expV = expQ.pop_front();
            `CHK({pslverr, prdata}, expV)
        end
    end

    task automatic printVerdict;
        if (failCount == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : printVerdict

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        logic [31:0] q;
        expQ.push_back(e);
        host.xfer(a, 1'b0, 32'h0, q);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(a, 1'b1, d, q);
    endtask : wr

    task automatic wait_idle;
        int n;
        n = 0;
        repeat (3) @(negedge mclk);
        while (phase !== PH_IDLE && n < 4000) begin
            @(negedge mclk);
            n++;
        end
    endtask : wait_idle

    // one routine call, busy result and array block checked while a program or erase runs
    task automatic call_op(input logic [1:0] code, input logic [31:0] arg0, input logic [31:0] arg1,
        input logic [7:0] res);
        wr(`FPS_OFF_ARG0, arg0);
        wr(`FPS_OFF_ARG1, arg1);
        wr(`FPS_OFF_CALL, {30'h0, code});
        if (res === `FPS_RES_OK && code !== `FPS_CALL_INIT) begin
            rd(`FPS_OFF_RESULT, {25'h0, `FPS_RES_BUSY});
            `CHK(arrayBlock, 1'b1)
        end
        wait_idle();
        rd(`FPS_OFF_RESULT, {25'h0, res});
        rd(`FPS_OFF_ARG1, {1'b0, arg1});
    endtask : call_op

    // watchdog
    initial begin
        repeat (40000) @(posedge mclk);
        failCount++;
        printVerdict();
    end

    initial begin
        logic [1:0] sels [4];
        logic [15:0] tgt;
        logic [31:0] src, dst;
        sels = '{2'b11, 2'b00, 2'b01, 2'b10};
        sysRst = 1'b1;
        userBootPin = 1'b0;
        ramExec = 1'b1;
        void'($urandom(69665));
        repeat (2) @(posedge mclk);
        `CHK(entryAddr, 16'h0010)
        sysRst <= 1'b0;
        wait_idle();
        rd(`FPS_OFF_ARRSEL, 33'h0);
        rd(8'h30, {1'b1, 32'h0});
        // refused requests: no key, then not from ram
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            ramExec <= (i == 0);
            wr(`FPS_OFF_PSEL, 32'h1);
            wr(`FPS_OFF_KEY, (i == 0) ? 32'h0 : 32'hA5);
            wr(`FPS_OFF_CODE, 32'h1);
            repeat (3) @(negedge mclk);
            `CHK(phase, PH_IDLE)
        end
        @(posedge mclk);
        ramExec <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            tgt = 16'h0100 * 16'(i + 1);
            wr(`FPS_OFF_DLTGT, {16'h0, tgt});
            wr(`FPS_OFF_PSEL, {31'h0, sels[i][1]});
            wr(`FPS_OFF_ESEL, {31'h0, sels[i][0]});
            wr(`FPS_OFF_KEY, 32'hA5);
            wr(`FPS_OFF_CODE, 32'h1);
            wait_idle();
            rd(`FPS_OFF_DLRES, {25'h0, (sels[i][1] ^ sels[i][0]) ? `FPS_DL_OK : `FPS_DL_SS});
            `CHK(entryAddr, tgt + 16'h0010)
            `CHK(initEntryAddr, tgt + 16'h0020)
        end
        call_op(`FPS_CALL_INIT, 32'd100, 32'h0, `FPS_RES_FREQ);
        call_op(`FPS_CALL_INIT, 32'd2000 + $urandom_range(0, 500), 32'h0, `FPS_RES_OK);
        wr(`FPS_OFF_KEY, 32'h5A);
        call_op(`FPS_CALL_ERASE, 32'd8, 32'h0, `FPS_RES_ADDR);
        call_op(`FPS_CALL_ERASE, 32'd2, 32'h0, `FPS_RES_OK);
        call_op(`FPS_CALL_ERASE, 32'd2, 32'h0, `FPS_RES_OK);
        // program two units in the erased block
        src = 32'h0000_2000 + ($urandom_range(0, 63) << 7);
        dst = (32'd8 + $urandom_range(0, 2)) << 7;
        call_op(`FPS_CALL_PROG, src, dst + 32'h1, `FPS_RES_ADDR);
        call_op(`FPS_CALL_PROG, 32'h0000_0800, dst, `FPS_RES_SRC);
        call_op(`FPS_CALL_PROG, src, dst, `FPS_RES_OK);
        call_op(`FPS_CALL_PROG, src + 32'h80, dst + 32'h80, `FPS_RES_OK);
        call_op(`FPS_CALL_PROG, src, dst, `FPS_RES_WRERR);
        wr(`FPS_OFF_KEY, 32'h0);
        call_op(`FPS_CALL_PROG, src, dst + 32'h100, `FPS_RES_KEY);
        // long reset, then user boot mode
        @(posedge mclk);
        sysRst <= 1'b1;
        userBootPin <= 1'b1;
        repeat (2000) @(posedge mclk);
        sysRst <= 1'b0;
        @(negedge mclk);
        `CHK(irqHold, 1'b1)
        wait_idle();
        rd(`FPS_OFF_ARRSEL, {25'h0, `FPS_ARR_BOOT});
        `CHK(bootArrayVisible, 1'b1)
        wr(`FPS_OFF_ARRSEL, 32'h0);
        repeat (2) @(negedge mclk);
        `CHK(irqHold, 1'b1)
        wait_idle();
        `CHK(bootArrayVisible, 1'b0)
        rd(`FPS_OFF_ARRSEL, 33'h0);
        printVerdict();
    end
endmodule : fps_top_tb
